/* common/three_port_pin_io_defines.vh */
// Operation
// - Three ports, eighteen pins, byte data registers
// - Reset clears all three data registers
// - Data registers at E0H, E1H, E2H
// - First port pins: input or push-pull
// - First port per-pin pull-up select
// - First port alternates: ADC, interrupts, PWM
// - First port config at E6H and E7H
// - Second port: in/push-pull/open-drain, pull up/down
// - Second port option pins; bit two input-only
// - Third port modes, pull-up, ADC/clock/timer alternates
// - Pending bit1 enables irq0, bit0 pending
// - Pending bit3 enables irq1, bit2 pending
`ifndef THREE_PORT_PIN_IO_DEFINES_VH
`define THREE_PORT_PIN_IO_DEFINES_VH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_FIRST_DATA 8'hE0
`define ADDR_SECOND_DATA 8'hE1
`define ADDR_THIRD_DATA 8'hE2
`define ADDR_FIRST_CON_HI 8'hE6
`define ADDR_FIRST_CON_LO 8'hE7
`define ADDR_IRQ_PEND 8'hE8
`define ADDR_SECOND_CON 8'hE9
`define ADDR_THIRD_CON_HI 8'hEA
`define ADDR_THIRD_CON_LO 8'hEB

// ****************************************
// Reset values
// ****************************************
`define RST_DATA 8'h00
`define RST_CON 8'h00
`define RST_PEND 4'h0

// ****************************************
// Pending register fields
// ****************************************
`define PEND_IRQ0_FLAG 0
`define PEND_IRQ0_EN 1
`define PEND_IRQ1_FLAG 2
`define PEND_IRQ1_EN 3

// ****************************************
// Two-bit pin mode codes
// ****************************************
`define MODE_IN 2'h0
`define MODE_IN_PULL 2'h1
`define MODE_PUSH_PULL 2'h2
`define MODE_ALT 2'h3
`define MODE_OPEN_DRAIN 2'h3

// ****************************************
// Fixed pin assignments
// ****************************************
`define PIN_IRQ0 0
`define PIN_IRQ1 1
`define PIN_PWM 6
`define THIRD_ALT_BIT 6
`define SECOND_PIN2_PU 6
`define SECOND_PIN2_PD 7

`endif

/* hw/pin_sync.v */
`timescale 1ns/1ns
// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module pin_sync #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Asynchronous pins in, synchronised copy out
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_ff; // First stage, read only by second
  reg [WIDTH-1:0] sync_ff; // Second stage, safe to use

  // Two flops in series
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

/* hw/three_port_pin_io.v */
`timescale 1ns/1ns
`include "three_port_pin_io_defines.vh"
module three_port_pin_io (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // CPU register port
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o,
  // First port pins
  input wire [7:0] p0_in_i,
  output wire [7:0] p0_out_o,
  output wire [7:0] p0_oe_o,
  output wire [7:0] p0_pull_up_o,
  output wire [7:0] p0_analog_o,
  // Second port pins
  input wire [2:0] p1_in_i,
  output wire [2:0] p1_out_o,
  output wire [2:0] p1_oe_o,
  output wire [2:0] p1_pull_up_o,
  output wire [2:0] p1_pull_down_o,
  // Third port pins
  input wire [6:0] p2_in_i,
  output wire [6:0] p2_out_o,
  output wire [6:0] p2_oe_o,
  output wire [6:0] p2_pull_up_o,
  output wire [6:0] p2_analog_o,
  // Factory option and alternate sources
  input wire osc_reset_option_i,
  input wire pwm_i,
  input wire sys_clk_out_i,
  input wire timer_zero_out_i,
  // External interrupt flags to the interrupt controller
  output wire [1:0] ext_irq_o
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  reg rst_meta_ff; // First reset stage
  reg rst_n_ff; // Released reset used everywhere

  // Assert at once, release after two edges
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [17:0] pins_sync; // All 18 pins after two flops, pin count
  wire [7:0] p0_sync;
  wire [2:0] p1_sync;
  wire [6:0] p2_sync;

  pin_sync #(.WIDTH(18)) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .async_i({p2_in_i, p1_in_i, p0_in_i}),
    .sync_o(pins_sync)
  );

  assign p0_sync = pins_sync[7:0];
  assign p1_sync = pins_sync[10:8];
  assign p2_sync = pins_sync[17:11];

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] p0_data_ff; // First port data latch
  reg [2:0] p1_data_ff; // Second port data latch
  reg [6:0] p2_data_ff; // Third port data latch
  reg [7:0] p0_con_hi_ff; // Pins 7..4, two bits each
  reg [7:0] p0_con_lo_ff; // Pins 3..0, two bits each
  reg [7:0] p1_con_ff; // Pins 1..0 modes, pin 2 pulls
  reg [6:0] p2_con_hi_ff; // Pins 6..4 modes, alternate enable
  reg [7:0] p2_con_lo_ff; // Pins 3..0 modes
  reg [3:0] pend_ff; // Interrupt enables and pending flags
  reg [7:0] rdata_ff; // Registered read data
  reg [1:0] irq_pin_ff; // Last seen level of interrupt pins

  // Two-bit mode of pin n from a high/low register pair
  function [1:0] pin_mode;
    input [7:0] hi;
    input [7:0] lo;
    input integer n;
    reg [15:0] both;
    begin
      both = {hi, lo};
      pin_mode = both[2*n +: 2];
    end
  endfunction

  // ****************************************
  // Pin drive decode
  // ****************************************
  reg [7:0] p0_out, p0_oe, p0_pu, p0_an, p0_is_out;
  reg [2:0] p1_out, p1_oe, p1_pu, p1_pd, p1_is_out;
  reg [6:0] p2_out, p2_oe, p2_pu, p2_an, p2_is_out;
  reg [1:0] md;
  integer i;

  // First port: input, pulled input, push-pull or alternate
  always @* begin
    md = 2'h0;
    p0_out = 8'h00;
    p0_oe = 8'h00;
    p0_pu = 8'h00;
    p0_an = 8'h00;
    p0_is_out = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      md = pin_mode(p0_con_hi_ff, p0_con_lo_ff, i);
      case (md)
        `MODE_IN_PULL: begin
          p0_pu[i] = 1'b1;
        end
        `MODE_PUSH_PULL: begin
          p0_out[i] = p0_data_ff[i];
          p0_oe[i] = 1'b1;
          p0_is_out[i] = 1'b1;
        end
        `MODE_ALT: begin
          // Interrupt pins stay plain inputs, PWM pin drives, rest analog
          if (i == `PIN_PWM) begin
            p0_out[i] = pwm_i;
            p0_oe[i] = 1'b1;
          end else if (i != `PIN_IRQ0 && i != `PIN_IRQ1) begin
            p0_an[i] = 1'b1;
          end
        end
        default: begin
          p0_out[i] = 1'b0;
        end
      endcase
    end
  end

  // Second port: option pins released, pin 2 input only
  always @* begin
    p1_out = 3'h0;
    p1_oe = 3'h0;
    p1_pu = 3'h0;
    p1_pd = 3'h0;
    p1_is_out = 3'h0;
    for (i = 0; i < 2; i = i + 1) begin
      case (p1_con_ff[2*i +: 2])
        `MODE_IN: p1_pu[i] = 1'b1;
        `MODE_IN_PULL: p1_pd[i] = 1'b1;
        `MODE_PUSH_PULL: begin
          p1_oe[i] = 1'b1;
          p1_out[i] = p1_data_ff[i];
          p1_is_out[i] = 1'b1;
        end
        default: begin
          // Open drain: drive low only, release for one
          p1_oe[i] = ~p1_data_ff[i];
          p1_is_out[i] = 1'b1;
        end
      endcase
    end
    p1_pu[2] = p1_con_ff[`SECOND_PIN2_PU];
    p1_pd[2] = p1_con_ff[`SECOND_PIN2_PD];
    // Oscillator and reset option takes pins away from software
    if (osc_reset_option_i) begin
      p1_oe = 3'h0;
      p1_pu = 3'h0;
      p1_pd = 3'h0;
      p1_is_out = 3'h0;
    end
  end

  // Third port: modes plus clock, timer and analog alternates
  always @* begin
    p2_out = 7'h00;
    p2_oe = 7'h00;
    p2_pu = 7'h00;
    p2_an = 7'h00;
    p2_is_out = 7'h00;
    for (i = 0; i < 7; i = i + 1) begin
      case (pin_mode({1'b0, p2_con_hi_ff}, p2_con_lo_ff, i))
        `MODE_IN: p2_pu[i] = 1'b0;
        `MODE_IN_PULL: p2_pu[i] = 1'b1;
        `MODE_PUSH_PULL: begin
          p2_oe[i] = 1'b1;
          p2_out[i] = p2_data_ff[i];
          p2_is_out[i] = 1'b1;
        end
        default: begin
          p2_oe[i] = ~p2_data_ff[i];
          p2_is_out[i] = 1'b1;
        end
      endcase
    end
    // Alternate enable overrides every pin mode
    if (p2_con_hi_ff[`THIRD_ALT_BIT]) begin
      p2_out = {5'h00, timer_zero_out_i, sys_clk_out_i};
      p2_oe = 7'h03;
      p2_an = 7'h7C;
      p2_pu = 7'h00;
      p2_is_out = 7'h00;
    end
  end

  assign p0_out_o = p0_out;
  assign p0_oe_o = p0_oe;
  assign p0_pull_up_o = p0_pu;
  assign p0_analog_o = p0_an;
  assign p1_out_o = p1_out;
  assign p1_oe_o = p1_oe;
  assign p1_pull_up_o = p1_pu;
  assign p1_pull_down_o = p1_pd;
  assign p2_out_o = p2_out;
  assign p2_oe_o = p2_oe;
  assign p2_pull_up_o = p2_pu;
  assign p2_analog_o = p2_an;

  // ****************************************
  // External interrupt edges
  // ****************************************
  wire irq0_sel; // Pin 0 in alternate mode
  wire irq1_sel; // Pin 1 in alternate mode
  wire [1:0] irq_fall; // Falling edge seen on a selected pin
  wire pend_wr;

  assign irq0_sel = (pin_mode(p0_con_hi_ff, p0_con_lo_ff, `PIN_IRQ0) == `MODE_ALT);
  assign irq1_sel = (pin_mode(p0_con_hi_ff, p0_con_lo_ff, `PIN_IRQ1) == `MODE_ALT);
  assign irq_fall[0] = irq0_sel & irq_pin_ff[0] & ~p0_sync[`PIN_IRQ0];
  assign irq_fall[1] = irq1_sel & irq_pin_ff[1] & ~p0_sync[`PIN_IRQ1];
  assign pend_wr = wr_i && (addr_i == `ADDR_IRQ_PEND);

  // ****************************************
  // Register writes
  // ****************************************
  // Store writes; the flag set by an edge beats a clearing write
  always @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      p0_data_ff <= `RST_DATA;
      p1_data_ff <= 3'h0;
      p2_data_ff <= 7'h00;
      p0_con_hi_ff <= `RST_CON;
      p0_con_lo_ff <= `RST_CON;
      p1_con_ff <= `RST_CON;
      p2_con_hi_ff <= 7'h00;
      p2_con_lo_ff <= `RST_CON;
      pend_ff <= `RST_PEND;
      irq_pin_ff <= 2'h0;
    end else begin
      irq_pin_ff <= {p0_sync[`PIN_IRQ1], p0_sync[`PIN_IRQ0]};
      if (wr_i) begin
        case (addr_i)
          `ADDR_FIRST_DATA: p0_data_ff <= wdata_i;
          `ADDR_SECOND_DATA: p1_data_ff <= wdata_i[2:0];
          `ADDR_THIRD_DATA: p2_data_ff <= wdata_i[6:0];
          `ADDR_FIRST_CON_HI: p0_con_hi_ff <= wdata_i;
          `ADDR_FIRST_CON_LO: p0_con_lo_ff <= wdata_i;
          `ADDR_SECOND_CON: p1_con_ff <= wdata_i;
          `ADDR_THIRD_CON_HI: p2_con_hi_ff <= wdata_i[6:0];
          `ADDR_THIRD_CON_LO: p2_con_lo_ff <= wdata_i;
          default: p0_data_ff <= p0_data_ff;
        endcase
      end
      // Enables are plain storage
      if (pend_wr) begin
        pend_ff[`PEND_IRQ0_EN] <= wdata_i[`PEND_IRQ0_EN];
        pend_ff[`PEND_IRQ1_EN] <= wdata_i[`PEND_IRQ1_EN];
      end
      // Writing one keeps a flag, zero clears it, edge sets it
      pend_ff[`PEND_IRQ0_FLAG] <= irq_fall[0] | (pend_ff[`PEND_IRQ0_FLAG] &
        (~pend_wr | wdata_i[`PEND_IRQ0_FLAG]));
      pend_ff[`PEND_IRQ1_FLAG] <= irq_fall[1] | (pend_ff[`PEND_IRQ1_FLAG] &
        (~pend_wr | wdata_i[`PEND_IRQ1_FLAG]));
    end
  end

  assign ext_irq_o[0] = pend_ff[`PEND_IRQ0_FLAG] & pend_ff[`PEND_IRQ0_EN];
  assign ext_irq_o[1] = pend_ff[`PEND_IRQ1_FLAG] & pend_ff[`PEND_IRQ1_EN];

  // ****************************************
  // Register reads
  // ****************************************
  // Push-pull and open-drain pins return the latch unless the option or the third port alternate enable takes them; all other pins return the synchronised pin
  always @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_FIRST_DATA:
          rdata_ff <= (p0_data_ff & p0_is_out) | (p0_sync & ~p0_is_out);
        `ADDR_SECOND_DATA:
          rdata_ff <= {5'h00, (p1_data_ff & p1_is_out) | (p1_sync & ~p1_is_out)};
        `ADDR_THIRD_DATA:
          rdata_ff <= {1'b0, (p2_data_ff & p2_is_out) | (p2_sync & ~p2_is_out)};
        `ADDR_FIRST_CON_HI: rdata_ff <= p0_con_hi_ff;
        `ADDR_FIRST_CON_LO: rdata_ff <= p0_con_lo_ff;
        `ADDR_IRQ_PEND: rdata_ff <= {4'h0, pend_ff};
        `ADDR_SECOND_CON: rdata_ff <= p1_con_ff;
        `ADDR_THIRD_CON_HI: rdata_ff <= {1'b0, p2_con_hi_ff};
        `ADDR_THIRD_CON_LO: rdata_ff <= p2_con_lo_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_ff;

endmodule

/* test/pin_model.sv */
`timescale 1ns/1ns
// ****************************************
// Board pad levels
// ****************************************
module pin_model #(
  parameter int W = 8
) (
  // Design drive and pulls
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] pu_i,
  input wire logic [W-1:0] pd_i,
  // Weak far-side source
  input wire logic [W-1:0] ext_i,
  // Resolved pad level
  output logic [W-1:0] lvl_o
);
  // Drive beats pull, pull beats the weak far side
  always_comb begin
    for (int k = 0; k < W; k++) begin
      lvl_o[k] = oe_i[k] ? out_i[k] : pu_i[k] ? 1'b1 : pd_i[k] ? 1'b0 : ext_i[k];
    end
  end
endmodule

/* test/pio_sva.sv */
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module pio_sva (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire [7:0] p0_out_o,
  input wire [7:0] p0_oe_o,
  input wire [7:0] p0_analog_o,
  input wire [2:0] p1_oe_o,
  input wire [2:0] p1_pull_up_o,
  input wire [2:0] p1_pull_down_o,
  input wire osc_reset_option_i,
  input wire [1:0] ext_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Reset must hold read data, first port drive and interrupts quiet
  a_rst_quiet: assert property (disable iff (1'b0)
    !rstn_i |-> rdata_o == 8'h00 && p0_oe_o == 8'h00 && ext_irq_o == 2'h0)
    else $error("outputs not clear in reset");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'hE3 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without read");
  a_data_readback: assert property (
    wr_i && !rd_i && addr_i == 8'hE0 ##1 rd_i && !wr_i && addr_i == 8'hE0
    |=> rdata_o == $past(wdata_i, 2)) else $error("back to back readback wrong");
  // PWM pin excluded, it follows its own source
  a_pins_follow: assert property (wr_i && addr_i == 8'hE0 |=>
    ((p0_out_o ^ $past(wdata_i)) & p0_oe_o & 8'hBF) == 8'h00)
    else $error("driven pin differs from data");
  a_pin2_input: assert property (p1_oe_o[2] == 1'b0)
    else $error("input-only pin driven");
  a_option_off: assert property (osc_reset_option_i ##1 osc_reset_option_i |->
    (p1_oe_o | p1_pull_up_o | p1_pull_down_o) == 3'h0) else $error("option pins not released");
  a_analog_nodrive: assert property ((p0_analog_o & p0_oe_o) == 8'h00)
    else $error("analog pin driven");
  a_irq0_mask: assert property (wr_i && addr_i == 8'hE8 && !wdata_i[1] |=> !ext_irq_o[0])
    else $error("masked irq0 raised");
  a_irq1_mask: assert property (wr_i && addr_i == 8'hE8 && !wdata_i[3] |=> !ext_irq_o[1])
    else $error("masked irq1 raised");
  c_pend_read: cover property (rd_i && addr_i == 8'hE8);
  c_irq_up: cover property (ext_irq_o != 2'h0);
  c_option: cover property (osc_reset_option_i);
endmodule

/* test/tb.sv */
`timescale 1ns/1ns
// ****************************************
// Bench top
// ****************************************
module tb;
  logic clk_i = 1'b0, rstn_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
  logic [7:0] p0_in_i, p0_out_o, p0_oe_o, p0_pull_up_o, p0_analog_o, ext0 = 8'h00;
  logic [2:0] p1_in_i, p1_out_o, p1_oe_o, p1_pull_up_o, p1_pull_down_o, ext1 = 3'h0;
  logic [6:0] p2_in_i, p2_out_o, p2_oe_o, p2_pull_up_o, p2_analog_o, ext2 = 7'h00;
  logic osc_reset_option_i = 1'b0, pwm_i = 1'b0, sys_clk_out_i = 1'b0, timer_zero_out_i = 1'b0;
  logic [1:0] ext_irq_o;
  int num_errors = 0, checks = 0;
  // Address, write data, expected readback; pin modes set before each data row
  logic [23:0] rows [0:11] = '{24'hE6AAAA, 24'hE7AAAA, 24'hE05555, 24'hE94F4F, 24'hE1FF07,
    24'hEA2A2A, 24'hEBAAAA, 24'hE2FF7F, 24'hEAFF7F, 24'hE3FF00, 24'hECFF00, 24'hE80A0A};
  always #2 clk_i = ~clk_i;
  three_port_pin_io uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .p0_in_i(p0_in_i),
    .p0_out_o(p0_out_o), .p0_oe_o(p0_oe_o), .p0_pull_up_o(p0_pull_up_o),
    .p0_analog_o(p0_analog_o), .p1_in_i(p1_in_i), .p1_out_o(p1_out_o), .p1_oe_o(p1_oe_o),
    .p1_pull_up_o(p1_pull_up_o), .p1_pull_down_o(p1_pull_down_o), .p2_in_i(p2_in_i),
    .p2_out_o(p2_out_o), .p2_oe_o(p2_oe_o), .p2_pull_up_o(p2_pull_up_o),
    .p2_analog_o(p2_analog_o), .osc_reset_option_i(osc_reset_option_i), .pwm_i(pwm_i),
    .sys_clk_out_i(sys_clk_out_i), .timer_zero_out_i(timer_zero_out_i), .ext_irq_o(ext_irq_o));
  pin_model #(.W(8)) pads0 (.oe_i(p0_oe_o), .out_i(p0_out_o), .pu_i(p0_pull_up_o),
    .pd_i(8'h00), .ext_i(ext0), .lvl_o(p0_in_i));
  pin_model #(.W(3)) pads1 (.oe_i(p1_oe_o), .out_i(p1_out_o), .pu_i(p1_pull_up_o),
    .pd_i(p1_pull_down_o), .ext_i(ext1), .lvl_o(p1_in_i));
  pin_model #(.W(7)) pads2 (.oe_i(p2_oe_o), .out_i(p2_out_o), .pu_i(p2_pull_up_o),
    .pd_i(7'h00), .ext_i(ext2), .lvl_o(p2_in_i));
  // One register write, strobe dropped after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // Let the taking edge settle before anyone looks at the outputs
    #1;
  endtask
  // One register read, data sampled a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    #1 d = rdata_o;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #40000;
    num_errors++;
    give_verdict;
  end
  initial begin
    // Falling edge at time zero so the asynchronous clear really happens
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (rows[i]) begin
      rd(rows[i][23:16], v);
      // Second port pins 0 and 1 come out of reset pulled up
      chk(v, (rows[i][23:16] == 8'hE1) ? 8'h03 : 8'h00);
    end
    $display("reset values done");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], v);
      chk(v, rows[i][7:0]);
    end
    $display("table done");
    // Push-pull, then read straight behind the write
    wr(8'hE6, 8'hAA);
    wr(8'hE7, 8'hAA);
    @(posedge clk_i);
    addr_i <= 8'hE0;
    wdata_i <= 8'hC3;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(rdata_o, 8'hC3);
    chk(p0_oe_o, 8'hFF);
    chk(p0_out_o, 8'hC3);
    // Upper nibble pulled up, lower nibble plain input
    wr(8'hE6, 8'h55);
    wr(8'hE7, 8'h00);
    ext0 <= 8'h0A;
    repeat (4) @(posedge clk_i);
    rd(8'hE0, v);
    chk(v, 8'hFA);
    chk(p0_pull_up_o, 8'hF0);
    $display("first port done");
    // Alternates, then both external interrupts
    ext0 <= 8'h03;
    pwm_i <= 1'b1;
    wr(8'hE6, 8'hFF);
    wr(8'hE7, 8'hFF);
    wr(8'hE8, 8'h0A);
    chk(p0_analog_o, 8'hBC);
    chk(p0_out_o & p0_oe_o, 8'h40);
    for (int k = 0; k < 2; k++) begin
      ext0 <= 8'h03 & ~(8'h01 << k);
      repeat (6) @(posedge clk_i);
      wr(8'hE8, 8'hFF);
      rd(8'hE8, v);
      chk(v, 8'h0A | (8'h01 << (2 * k)));
      chk({6'h00, ext_irq_o}, 8'h01 << k);
      wr(8'hE8, ~(8'h01 << (2 * k)));
      rd(8'hE8, v);
      chk(v, 8'h0A);
      ext0 <= 8'h03;
      repeat (6) @(posedge clk_i);
    end
    // Disabled interrupt still flags but stays off the output
    wr(8'hE8, 8'h00);
    ext0 <= 8'h02;
    repeat (6) @(posedge clk_i);
    rd(8'hE8, v);
    chk(v, 8'h01);
    chk({6'h00, ext_irq_o}, 8'h00);
    $display("interrupts done");
    // Second port: push-pull, open-drain, input-only pin
    wr(8'hE9, 8'h0E);
    wr(8'hE1, 8'h01);
    ext1 <= 3'h4;
    chk({5'h00, p1_oe_o}, 8'h03);
    chk({5'h00, p1_out_o & p1_oe_o}, 8'h01);
    repeat (4) @(posedge clk_i);
    rd(8'hE1, v);
    chk(v, 8'h05);
    wr(8'hE9, 8'h84);
    chk({2'h0, p1_pull_up_o, p1_pull_down_o}, 8'h0E);
    wr(8'hE9, 8'h8A);
    osc_reset_option_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({2'h0, p1_oe_o, p1_pull_down_o}, 8'h00);
    osc_reset_option_i <= 1'b0;
    $display("second port done");
    // Third port outputs, then alternates
    wr(8'hEA, 8'h2A);
    wr(8'hEB, 8'hAA);
    wr(8'hE2, 8'h55);
    chk({1'b0, p2_oe_o}, 8'h7F);
    chk({1'b0, p2_out_o}, 8'h55);
    sys_clk_out_i <= 1'b1;
    wr(8'hEB, 8'h00);
    wr(8'hEA, 8'h40);
    chk({1'b0, p2_analog_o}, 8'h7C);
    chk({1'b0, p2_out_o & p2_oe_o}, 8'h01);
    $display("third port done");
    // Reset in mid-run clears the third port data register
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'hE2, v);
    chk(v, 8'h00);
    $display("second reset done");
    give_verdict;
  end
endmodule
bind three_port_pin_io pio_sva sva (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .p0_out_o(p0_out_o),
  .p0_oe_o(p0_oe_o), .p0_analog_o(p0_analog_o), .p1_oe_o(p1_oe_o),
  .p1_pull_up_o(p1_pull_up_o), .p1_pull_down_o(p1_pull_down_o),
  .osc_reset_option_i(osc_reset_option_i), .ext_irq_o(ext_irq_o));
